// ### inc/fis_pkg.sv
// Constants, field layouts and state types of the fast interrupt selector.
// Assumes a 32-bit AHB-Lite register bus and eight peripheral request lines.
package fis_pkg;

    localparam int          NUM_SRC     = 8;
    localparam int          SEL_W       = 4;
    localparam int          IDX_W       = 3;
    localparam int          DEC_W       = 8;

    // Byte offsets of the two registers inside the block's address window.
    localparam logic [7:0]  OFF_PEND    = 8'h00;
    localparam logic [7:0]  OFF_CTRL    = 8'h04;

    localparam int          PEND_BIT    = 0;
    localparam int          GATE_BIT    = 7;
    localparam int          SEL_ON_BIT  = 3;

    localparam logic [7:0]  PEND_RST    = 8'h00;
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [7:0]  CTRL_MASK   = 8'h8F;

    localparam logic [1:0]  HTRANS_NSEQ = 2'h2;
    localparam logic [2:0]  HSIZE_WORD  = 3'h2;

    typedef struct packed {
        logic                   global_gate;
        logic [2:0]             rsvd;
        logic [SEL_W-1:0]       sel;
    } fis_ctrl_t;

    // Idle is stored high so that the inactive state is the output level itself.
    typedef enum logic {
        FIS_FIRING = 1'b0,
        FIS_IDLE   = 1'b1
    } fis_fiq_state_t;

    typedef struct packed {
        fis_fiq_state_t         fiq;
        logic                   pending;
        fis_ctrl_t              ctrl;
        logic [NUM_SRC-1:0]     svc;
        logic                   dp_wr;
        logic                   dp_pend;
        logic                   dp_ctrl;
        logic [31:0]            rdata;
        logic                   ready;
    } fis_state_t;

    localparam fis_state_t  ST_RST = '{
        fiq:     FIS_IDLE,
        pending: 1'b0,
        ctrl:    fis_ctrl_t'(CTRL_RST),
        svc:     8'h00,
        dp_wr:   1'b0,
        dp_pend: 1'b0,
        dp_ctrl: 1'b0,
        rdata:   32'h0000_0000,
        ready:   1'b1
    };

endpackage : fis_pkg

// ### logic/fis_src_mux.sv
// Source selection: picks one request for the fast path and detaches it.
// Assumes the request lines are already in the clk_sys domain.
`timescale 1ns/1ns
`default_nettype none
module fis_src_mux #(
    parameter int NUM_SRC = fis_pkg::NUM_SRC
) (
    input  wire logic [fis_pkg::SEL_W-1:0] sel,      // Select field, top bit enables
    input  wire logic [NUM_SRC-1:0]        src_irq,  // Peripheral request lines
    output logic                           fast_req, // Request of the chosen source
    output logic [NUM_SRC-1:0]             svc_node  // Requests left for service nodes
);

    logic [fis_pkg::IDX_W-1:0] idx;
    logic                      sel_on;

    always_comb begin
        idx      = sel[fis_pkg::IDX_W-1:0];
        sel_on   = sel[fis_pkg::SEL_ON_BIT];
        fast_req = 1'b0;
        svc_node = src_irq;
        if (sel_on) begin
            // Only the single indexed line can reach the fast path.
            fast_req      = src_irq[idx];
            svc_node[idx] = 1'b0;
        end
    end

endmodule : fis_src_mux
`default_nettype wire

// ### logic/fis_top.sv
// Fast interrupt selector: routes one of eight requests to the active-low
// fast interrupt line, with a sticky pending flag and a global gate.
// Assumes an AHB-Lite master on clk_sys, source lines and the standby flag
// driven by logic on the same clock.
`timescale 1ns/1ns
`default_nettype none
module fis_top #(
    parameter int NUM_SRC = fis_pkg::NUM_SRC
) (
    input  wire logic               clk_sys,          // System clock, 100 MHz
    input  wire logic               rst_n,            // Synchronous reset, active low
    input  wire logic               hsel,             // AHB slave select
    input  wire logic [31:0]        haddr,            // AHB address
    input  wire logic [1:0]         htrans,           // AHB transfer type
    input  wire logic               hwrite,           // AHB write when high
    input  wire logic [2:0]         hsize,            // AHB transfer size
    input  wire logic [31:0]        hwdata,           // AHB write data
    input  wire logic               hready,           // AHB bus ready
    output logic                    hreadyout,        // AHB slave ready
    output logic                    hresp,            // AHB response, always OKAY
    output logic [31:0]             hrdata,           // AHB read data
    input  wire logic               standby_block_on, // Standby enable flag
    input  wire logic [NUM_SRC-1:0] src_irq,          // Peripheral requests
    output logic [NUM_SRC-1:0]      service_node,     // Requests to service nodes
    output logic                    fast_irq_out_n    // Fast interrupt, active low
);

    fis_pkg::fis_state_t st;
    fis_pkg::fis_state_t st_nxt;

    logic                     sel_req;
    logic [NUM_SRC-1:0]       svc_raw;
    logic                     take;
    logic [fis_pkg::DEC_W-1:0] off;
    logic                     wr_pend;
    logic                     wr_ctrl;
    logic [31:0]              rd_val;

    fis_src_mux #(
        .NUM_SRC (NUM_SRC)
    ) u_mux (
        .sel      (st.ctrl.sel),
        .src_irq  (src_irq),
        .fast_req (sel_req),
        .svc_node (svc_raw)
    );

    // A zero-wait slave: the address phase is decoded here and the
    // write lands at the end of its data phase.
    assign take    = hsel & hready & (htrans == fis_pkg::HTRANS_NSEQ);
    assign off     = haddr[fis_pkg::DEC_W-1:0];
    assign wr_pend = st.dp_wr & st.dp_pend & standby_block_on;
    assign wr_ctrl = st.dp_wr & st.dp_ctrl & standby_block_on;

    always_comb begin
        rd_val = 32'h0000_0000;
        if (off == fis_pkg::OFF_PEND) begin
            rd_val[fis_pkg::PEND_BIT] = st.pending;
        end else if (off == fis_pkg::OFF_CTRL) begin
            rd_val[7:0] = st.ctrl;
        end
    end

    always_comb begin
        st_nxt         = st;
        st_nxt.ready   = 1'b1;
        st_nxt.dp_wr   = take & hwrite & (hsize == fis_pkg::HSIZE_WORD);
        st_nxt.dp_pend = take & (off == fis_pkg::OFF_PEND);
        st_nxt.dp_ctrl = take & (off == fis_pkg::OFF_CTRL);
        st_nxt.rdata   = (take & ~hwrite) ? rd_val : 32'h0000_0000;
        st_nxt.svc     = svc_raw;

        if (wr_pend) begin
            st_nxt.pending = hwdata[fis_pkg::PEND_BIT];
        end
        // A request in the same cycle as a clearing write is kept.
        if (sel_req) begin
            st_nxt.pending = 1'b1;
        end
        if (wr_ctrl) begin
            st_nxt.ctrl = fis_pkg::fis_ctrl_t'(hwdata[7:0] & fis_pkg::CTRL_MASK);
        end

        // There is no speed input: the logic runs on every clock of
        // clk_sys, rising edges only, whatever rate the core has been set to.
        unique case (st.fiq)
            fis_pkg::FIS_IDLE: begin
                if (st.pending & st.ctrl.global_gate) begin
                    st_nxt.fiq = fis_pkg::FIS_FIRING;
                end
            end
            fis_pkg::FIS_FIRING: begin
                // The gate is not looked at here, so clearing it waits
                // until the line has been released by software.
                if (!st.pending) begin
                    st_nxt.fiq = fis_pkg::FIS_IDLE;
                end
            end
        endcase

        if (!standby_block_on) begin
            st_nxt.fiq     = fis_pkg::FIS_IDLE;
            st_nxt.pending = 1'b0;
            st_nxt.ctrl    = fis_pkg::fis_ctrl_t'(fis_pkg::CTRL_RST);
            st_nxt.svc     = src_irq;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st <= fis_pkg::ST_RST;
        end else begin
            st <= st_nxt;
        end
    end

    assign hreadyout      = st.ready;
    assign hresp          = 1'b0;
    assign hrdata         = st.rdata;
    assign service_node   = st.svc;
    assign fast_irq_out_n = st.fiq;

    // Checks on the block's own behaviour.
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    logic [fis_pkg::IDX_W-1:0] idx_q;
    assign idx_q = st.ctrl.sel[fis_pkg::IDX_W-1:0];

    a_standby_resets_all: assert property (
        !standby_block_on |=> fast_irq_out_n && !st.pending
            && st.ctrl == fis_pkg::fis_ctrl_t'(fis_pkg::CTRL_RST)
    ) else $error("standby clear did not reset the block");

    a_standby_locks_writes: assert property (
        (!standby_block_on [*2]) |->
            st.ctrl == fis_pkg::fis_ctrl_t'(fis_pkg::CTRL_RST) && !st.pending
    ) else $error("register changed while standby flag clear");

    a_none_selected: assert property (
        (standby_block_on && !st.ctrl.sel[fis_pkg::SEL_ON_BIT]
            && !st.pending && !wr_pend) |=> !st.pending
    ) else $error("pending set with no source selected");

    a_only_chosen_source: assert property (
        (standby_block_on && !st.pending && !wr_pend
            && !src_irq[idx_q]) |=> !st.pending
    ) else $error("pending set by a source that is not routed");

    a_node_detached: assert property (
        (standby_block_on && st.ctrl.sel[fis_pkg::SEL_ON_BIT])
            |=> !service_node[$past(idx_q)]
    ) else $error("routed source still reaches its service node");

    a_pending_sticky: assert property (
        (standby_block_on && st.pending
            && !(wr_pend && !hwdata[fis_pkg::PEND_BIT])) |=> st.pending
    ) else $error("pending dropped without a clearing write");

    a_gate_fires: assert property (
        (standby_block_on && st.pending && st.ctrl.global_gate
            && fast_irq_out_n) |=> !fast_irq_out_n
    ) else $error("enabled pending request did not fire");

    a_active_holds: assert property (
        (standby_block_on && !fast_irq_out_n && st.pending)
            |=> !fast_irq_out_n
    ) else $error("active output ended while still pending");

    a_release_after_clear: assert property (
        (!fast_irq_out_n && !st.pending) |=> fast_irq_out_n
    ) else $error("output stayed active after pending cleared");

    a_gate_off_quiet: assert property (
        (fast_irq_out_n && !st.ctrl.global_gate) |=> fast_irq_out_n
    ) else $error("output fired with the gate clear");

    a_bus_zero_wait: assert property (
        take |=> (hreadyout && !hresp) [*2]
    ) else $error("bus slave inserted a wait or an error");

    // Helper terms for the checks below; they are read by assertions only,
    // so that each property can name one signal in its sampled-value calls.
    logic [NUM_SRC-1:0]        sel_mask;
    logic [7:0]                ctrl_wr_val;
    logic                      fire_ok;
    logic                      release_ok;

    assign sel_mask    = NUM_SRC'(1'b1) << idx_q;
    assign ctrl_wr_val = hwdata[7:0] & fis_pkg::CTRL_MASK;
    assign fire_ok     = st.pending & st.ctrl.global_gate & standby_block_on;
    assign release_ok  = ~st.pending | ~standby_block_on;

    // Bus side: read data stands for the data phase only and is zero otherwise.
    a_read_pend_data: assert property (
        (take && !hwrite && off == fis_pkg::OFF_PEND)
            |=> hrdata == {31'h0000_0000, $past(st.pending)}
    ) else $error("pending register read returned a wrong word");

    a_read_ctrl_data: assert property (
        (take && !hwrite && off == fis_pkg::OFF_CTRL)
            |=> hrdata == {24'h00_0000, $past(st.ctrl)}
    ) else $error("control register read returned a wrong word");

    a_read_unmapped: assert property (
        (take && !hwrite && off != fis_pkg::OFF_PEND && off != fis_pkg::OFF_CTRL)
            |=> hrdata == 32'h0000_0000
    ) else $error("unmapped read returned a nonzero word");

    a_read_idle_zero: assert property (
        !(take && !hwrite) |=> hrdata == 32'h0000_0000
    ) else $error("read data stood outside a read data phase");

    a_decode_pend: assert property (
        take |=> st.dp_pend == ($past(off) == fis_pkg::OFF_PEND)
    ) else $error("pending register decode went wrong");

    a_size_refused: assert property (
        (take && hwrite && hsize != fis_pkg::HSIZE_WORD) |=> !st.dp_wr
    ) else $error("a write that is not a whole word was accepted");

    a_idle_no_phase: assert property (
        !take |=> !st.dp_wr && !st.dp_pend && !st.dp_ctrl
    ) else $error("data phase started without an address phase");

    // Register contents.
    a_ctrl_write_lands: assert property (
        wr_ctrl |=> st.ctrl == $past(ctrl_wr_val)
    ) else $error("control write did not land");

    a_ctrl_holds: assert property (
        (standby_block_on && !wr_ctrl) |=> $stable(st.ctrl)
    ) else $error("control register changed without a write");

    a_ctrl_rsvd_zero: assert property (
        st.ctrl.rsvd == 3'h0
    ) else $error("reserved control bits were stored");

    a_standby_write_lost: assert property (
        (!standby_block_on && st.dp_wr)
            |=> st.ctrl == fis_pkg::fis_ctrl_t'(fis_pkg::CTRL_RST) && !st.pending
    ) else $error("write landed while standby flag clear");

    a_pend_write_set: assert property (
        (wr_pend && hwdata[fis_pkg::PEND_BIT]) |=> st.pending
    ) else $error("software set of pending was lost");

    a_pend_write_clear: assert property (
        (wr_pend && !hwdata[fis_pkg::PEND_BIT] && !sel_req) |=> !st.pending
    ) else $error("software clear of pending was lost");

    a_request_wins: assert property (
        (standby_block_on && sel_req) |=> st.pending
    ) else $error("routed request did not set pending");

    a_pend_no_cause: assert property (
        (standby_block_on && !st.pending && !sel_req
            && !(wr_pend && hwdata[fis_pkg::PEND_BIT])) |=> !st.pending
    ) else $error("pending set with no request and no write");

    // Routing of the requests.
    a_mux_one_source: assert property (
        sel_req |-> st.ctrl.sel[fis_pkg::SEL_ON_BIT] && src_irq[idx_q]
    ) else $error("fast request came from a line that is not routed");

    a_mux_detach: assert property (
        st.ctrl.sel[fis_pkg::SEL_ON_BIT] |-> !svc_raw[idx_q]
    ) else $error("routed line still passed to its service node");

    a_mux_none: assert property (
        !st.ctrl.sel[fis_pkg::SEL_ON_BIT] |-> svc_raw == src_irq && !sel_req
    ) else $error("select off still diverted a line");

    a_svc_pass_all: assert property (
        (standby_block_on && !st.ctrl.sel[fis_pkg::SEL_ON_BIT])
            |=> service_node == $past(src_irq)
    ) else $error("service nodes did not follow the requests");

    a_svc_pass_others: assert property (
        (standby_block_on && st.ctrl.sel[fis_pkg::SEL_ON_BIT])
            |=> (service_node | $past(sel_mask)) == ($past(src_irq) | $past(sel_mask))
    ) else $error("an unrouted line was withheld from its node");

    a_standby_svc: assert property (
        !standby_block_on |=> service_node == $past(src_irq)
    ) else $error("service nodes blocked while the block is off");

    // The output line moves only for a cause: it falls on a stored request with
    // the gate open, and rises only once pending has gone or the block is off.
    a_fire_needs_pend: assert property (
        (fast_irq_out_n && !st.pending) |=> fast_irq_out_n
    ) else $error("output fired with nothing pending");

    a_fall_cause: assert property (
        $fell(fast_irq_out_n) |-> $past(fire_ok)
    ) else $error("output fell without pending, gate and standby");

    a_rise_cause: assert property (
        $rose(fast_irq_out_n) |-> $past(release_ok)
    ) else $error("output released while still pending");

endmodule : fis_top
`default_nettype wire

// ### tb/fis_core_model.sv
// Behavioural model of the core's fast interrupt input.
// Assumes the line is driven on clk_sys and that the bench unmasks after service.
`timescale 1ns/1ns
`default_nettype none
module fis_core_model (
    input  wire logic       clk_sys,        // System clock
    input  wire logic       rst_n,          // Synchronous reset, active low
    input  wire logic       fast_irq_out_n, // Fast interrupt line, active low
    input  wire logic       f_unmask,       // Software re-enables fast interrupts
    output logic [7:0]      taken_cnt       // Interrupts taken so far
);
    logic masked_r;
    // Taking an entry masks the input, so a line left low is counted once until f_unmask is raised.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            masked_r  <= 1'b0;
            taken_cnt <= 8'h00;
        end else if (!masked_r && fast_irq_out_n === 1'b0) begin
            masked_r  <= 1'b1;
            taken_cnt <= taken_cnt + 8'h01;
        end else if (f_unmask) begin
            masked_r <= 1'b0;
        end
    end
endmodule : fis_core_model
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench of the fast interrupt selector over AHB-Lite.
// Assumes one slave on the bus, so hready is the slave's hreadyout.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, a, e); end end
module tb_top;
    logic        clk_sys, rst_n, hsel, hwrite, hreadyout, hresp, standby_block_on, f_unmask;
    logic [31:0] haddr, hwdata, hrdata, rd_val;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  src_irq, service_node, taken_cnt;
    logic        fast_irq_out_n;
    int          num_errors, samples_checked;
    localparam logic [7:0] P = fis_pkg::OFF_PEND;
    localparam logic [7:0] C = fis_pkg::OFF_CTRL;

    fis_top fis_top_inst (.clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .standby_block_on(standby_block_on), .src_irq(src_irq),
        .service_node(service_node), .fast_irq_out_n(fast_irq_out_n));
    fis_core_model fis_core_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .fast_irq_out_n(fast_irq_out_n), .f_unmask(f_unmask), .taken_cnt(taken_cnt));

    always #5 clk_sys = ~clk_sys;

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : cyc

    // One single word transfer; the data phase is held until hready is seen high.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= fis_pkg::HTRANS_NSEQ;
        hwrite <= wr;
        hsize  <= fis_pkg::HSIZE_WORD;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h00000000;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd_val = hrdata;
    endtask : xfer

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h00000000);
        `CHK(rd_val, e)
    endtask : rd

    // Pending is cleared before the core is unmasked, otherwise the line still low is taken a second time.
    task automatic clr_pend();
        src_irq <= 8'h00;
        xfer(1'b1, P, 32'h00000000);
        cyc(3);
        f_unmask <= 1'b1;
        cyc(1);
        f_unmask <= 1'b0;
    endtask : clr_pend

    task automatic close_out();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out

    initial begin
        #200000;
        num_errors++;
        close_out();
    end

    initial begin
        {clk_sys, hsel, hwrite, standby_block_on, f_unmask} = 5'h00;
        {haddr, hwdata, htrans, hsize, src_irq} = '0;
        rst_n = 1'b0;
        cyc(4);
        rst_n <= 1'b1;
        rd(P, 32'h00000000);
        rd(C, 32'h00000000);
        xfer(1'b1, C, 32'h0000008F);
        rd(C, 32'h00000000);
        standby_block_on <= 1'b1;
        xfer(1'b1, C, 32'h0000000B);
        rd(C, 32'h0000000B);
        src_irq <= 8'h28;
        cyc(3);
        `CHK(service_node, 8'h20)
        `CHK(fast_irq_out_n, 1'b1)
        rd(P, 32'h00000001);
        xfer(1'b1, C, 32'h0000008B);
        cyc(2);
        `CHK(fast_irq_out_n, 1'b0)
        xfer(1'b1, C, 32'h0000000B);
        cyc(3);
        `CHK(fast_irq_out_n, 1'b0)
        clr_pend();
        `CHK(fast_irq_out_n, 1'b1)
        rd(P, 32'h00000000);
        src_irq <= 8'h08;
        cyc(3);
        `CHK(fast_irq_out_n, 1'b1)
        clr_pend();
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, C, 32'h00000088 | i);
            src_irq <= ~(8'h01 << i);
            cyc(3);
            `CHK(fast_irq_out_n, 1'b1)
            `CHK(service_node, ~(8'h01 << i))
            src_irq <= 8'h01 << i;
            cyc(3);
            `CHK(service_node, 8'h00)
            `CHK(fast_irq_out_n, 1'b0)
            clr_pend();
        end
        xfer(1'b1, C, 32'h00000083);
        src_irq <= 8'hFF;
        cyc(3);
        `CHK(service_node, 8'hFF)
        rd(P, 32'h00000000);
        src_irq <= 8'h00;
        xfer(1'b1, P, 32'h00000001);
        cyc(3);
        `CHK(fast_irq_out_n, 1'b0)
        `CHK(taken_cnt, 8'h0A)
        standby_block_on <= 1'b0;
        cyc(2);
        `CHK(fast_irq_out_n, 1'b1)
        rd(P, 32'h00000000);
        rd(C, 32'h00000000);
        rd(8'h08, 32'h00000000);
        `CHK(hresp, 1'b0)
        close_out();
    end
endmodule : tb_top
`default_nettype wire
